/* rtl/msau_agu.sv */
// Address generation unit: post-increment with size scaling and mode handling
`timescale 1ns/100ps
module msau_agu
  import msau_pkg::*;
(
  // Request
  input  wire msau_req_type req_i,
  input  wire logic         dsp_en_i,
  // Result
  output logic [15:0]       ea_o,
  output logic [15:0]       next_ea_o
);

  logic [15:0] step;
  logic [15:0] inc;

  function automatic logic [15:0] bit_rev(input logic [15:0] a);
    logic [15:0] r;
    r = ZERO_WORD;
    for (int i = 0; i < 16; i++) begin
      r[i] = a[15-i];
    end
    return r;
  endfunction : bit_rev

  always_comb begin
    step = req_i.is_byte ? BYTE_STEP : WORD_STEP;
    // Near direct only sees a 13-bit field
    ea_o = req_i.near_direct
         ? {3'b000, req_i.ea[NEAR_FIELD_W-1:0]}
         : req_i.ea;
    inc = ea_o + step;
    next_ea_o = inc;
    if (dsp_en_i && req_i.mode == MSAU_MODE_MODULO &&
        ea_o >= req_i.mod_end) begin
      next_ea_o = req_i.mod_start;
    end else if (dsp_en_i && req_i.mode == MSAU_MODE_BITREV) begin
      next_ea_o = bit_rev(bit_rev(ea_o) + bit_rev(step));
    end
  end

endmodule : msau_agu

/* rtl/msau_pkg.sv */
// Package: constants and carrier types for the memory space access unit
package msau_pkg;

  localparam int unsigned DATA_W         = 16;
  localparam int unsigned PROG_ADDR_W    = 24;
  localparam int unsigned PAGE_W         = 9;
  localparam int unsigned EXT_ADDR_W     = 24;
  localparam int unsigned NEAR_FIELD_W   = 13;

  localparam logic [23:0] RESET_VECTOR   = 24'h00_0000;
  localparam logic [23:0] VECTOR_LAST    = 24'h00_0200;
  localparam logic [23:0] PROG_STEP      = 24'h00_0002;
  localparam logic [7:0]  UPPER_PAD      = 8'h00;

  localparam logic [15:0] SFR_LAST       = 16'h0FFF;
  localparam logic [15:0] NEAR_LAST      = 16'h1FFF;
  localparam logic [15:0] IMPL_LAST      = 16'hCFFF;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  localparam logic [15:0] BYTE_STEP      = 16'h0001;
  localparam logic [15:0] WORD_STEP      = 16'h0002;
  localparam logic [15:0] Y_BASE_DEF     = 16'h9000;
  localparam logic [PAGE_W-1:0] PAGE_RST = 9'h001;

  typedef enum logic [1:0] {
    MSAU_MODE_LINEAR = 2'b00,
    MSAU_MODE_MODULO = 2'b01,
    MSAU_MODE_BITREV = 2'b10
  } msau_mode_type;

  typedef enum logic [1:0] {
    MSAU_ST_RESET = 2'b00,
    MSAU_ST_RUN   = 2'b01,
    MSAU_ST_TRAP  = 2'b10
  } msau_state_type;

  // One data-space access request
  typedef struct packed {
    logic          valid;
    logic          is_byte;
    logic          near_direct;
    logic [15:0]   ea;
    msau_mode_type mode;
    logic [15:0]   mod_start;
    logic [15:0]   mod_end;
  } msau_req_type;

endpackage : msau_pkg

/* rtl/msau_top.sv */
// Memory space access unit: program fetch, data decode, lanes and traps
// Functional notes
// - Program locations are 24 bits: lower word plus upper word, top byte zero.
// - Lower program word at even address, upper word at next odd address.
// - Fetch address stays even; counter steps by two per word.
// - Program addresses 0x000000 to 0x000200 are reserved vectors.
// - Fetch starts at address zero; software puts a jump there.
// - Data space is 16 bits wide with separate read and write generators.
// - Data effective addresses are 16-bit byte addresses, 64 Kbytes.
// - Read and write pages extend the space to 16 Mbytes.
// - Reads outside the implemented 52 Kbytes return zero.
// - Low byte of a word at even address, high byte at odd.
// - Post-increment adds one for bytes, two for words.
// - Byte read picks a byte by address bit zero onto low lane.
// - Shared word decode, separate byte write enables.
// - Odd address on a word access raises the address error trap.
// - Misaligned read completes, misaligned write suppressed, then trap.
// - Byte load into working register changes only its low byte.
// - Addresses 0x0000 to 0x0FFF are special registers; unused read zero.
// - Direct instructions reach 0x1FFF via 13 bits; moves reach all.
// - Separate X and Y paths fetch two words in one cycle.
// - Y read only for multiply-accumulate class; X serves all else.
// - All writes use combined space; X/Y boundary is fixed.
// - Modulo on X and Y, bit-reverse on X writes, absent when reduced.
`timescale 1ns/100ps
module msau_top
  import msau_pkg::*;
#(
  parameter bit          DSP_EN = 1'b1,
  parameter logic [15:0] Y_BASE = Y_BASE_DEF
) (
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  SYS_RST_I,
  // Program fetch control
  input  wire logic                  FETCH_ADV_I,
  input  wire logic                  FETCH_BACK_I,
  input  wire logic                  FETCH_LOAD_I,
  input  wire logic [23:0]           FETCH_TARGET_I,
  input  wire logic [23:0]           PROG_RDATA_I,
  output logic [23:0]                PROG_ADDR_O,
  output logic [15:0]                PROG_LOWER_O,
  output logic [15:0]                PROG_UPPER_O,
  output logic                       PROG_VECTOR_O,
  // Page registers
  input  wire logic                  PAGE_WE_I,
  input  wire logic [PAGE_W-1:0]     READ_PAGE_I,
  input  wire logic [PAGE_W-1:0]     WRITE_PAGE_I,
  // X read request
  input  wire msau_req_type          XRD_REQ_I,
  input  wire logic                  MAC_CLASS_I,
  // Y read request
  input  wire msau_req_type          YRD_REQ_I,
  // Write request
  input  wire msau_req_type          WR_REQ_I,
  input  wire logic [15:0]           WR_DATA_I,
  // Working register byte merge
  input  wire logic [15:0]           WREG_OLD_I,
  // Memory array side
  input  wire logic [15:0]           XMEM_RDATA_I,
  input  wire logic [15:0]           YMEM_RDATA_I,
  input  wire logic                  SFR_HIT_I,
  output logic [EXT_ADDR_W-1:0]      XMEM_ADDR_O,
  output logic [EXT_ADDR_W-1:0]      YMEM_ADDR_O,
  output logic [EXT_ADDR_W-1:0]      WMEM_ADDR_O,
  output logic [1:0]                 WMEM_BE_O,
  output logic [15:0]                WMEM_DATA_O,
  // Results
  output logic [15:0]                XRD_DATA_O,
  output logic [15:0]                YRD_DATA_O,
  output logic [15:0]                WREG_DATA_O,
  output logic [15:0]                XRD_NEXT_EA_O,
  output logic [15:0]                YRD_NEXT_EA_O,
  output logic [15:0]                WR_NEXT_EA_O,
  output logic                       ADDR_TRAP_O
);

  function automatic logic misaligned(input msau_req_type r);
    return r.valid && !r.is_byte && r.ea[0];
  endfunction : misaligned

  function automatic logic [15:0] lane_sel(input logic [15:0] w,
                                           input logic        is_byte,
                                           input logic        a0);
    if (!is_byte) begin
      return w;
    end
    // Odd address holds the high byte
    return {8'h00, a0 ? w[15:8] : w[7:0]};
  endfunction : lane_sel

  function automatic logic implemented(input logic [15:0] ea,
                                       input logic        sfr_hit);
    if (ea <= SFR_LAST) begin
      return sfr_hit;
    end
    return ea <= IMPL_LAST;
  endfunction : implemented

  // Program fetch state
  msau_state_type st_r, st_nxt;
  logic [23:0]    pc_r, pc_nxt;
  logic [15:0]    plo_r, plo_nxt;
  logic [15:0]    pup_r, pup_nxt;
  logic           pvec_r, pvec_nxt;

  // Page state
  logic [PAGE_W-1:0] rpage_r, rpage_nxt;
  logic [PAGE_W-1:0] wpage_r, wpage_nxt;

  // Data path state
  logic [EXT_ADDR_W-1:0] xa_r, xa_nxt, ya_r, ya_nxt, wa_r, wa_nxt;
  logic [1:0]            be_r, be_nxt;
  logic [15:0]           wd_r, wd_nxt;
  logic [15:0]           xd_r, xd_nxt, yd_r, yd_nxt, wreg_r, wreg_nxt;
  logic [15:0]           xn_r, xn_nxt, yn_r, yn_nxt, wn_r, wn_nxt;
  logic                  trap_r, trap_nxt;
  logic                  xrd_pend_r, xrd_pend_nxt;
  logic                  yrd_pend_r, yrd_pend_nxt;
  logic                  xbyte_r, xbyte_nxt, xa0_r, xa0_nxt;
  logic                  ybyte_r, ybyte_nxt, ya0_r, ya0_nxt;
  logic                  ximp_r, ximp_nxt, yimp_r, yimp_nxt;

  logic [15:0] x_ea, x_next, y_ea, y_next, w_ea, w_next;
  msau_req_type wr_req_x;

  // Bit-reverse is only legal for writes on X
  always_comb begin
    wr_req_x = WR_REQ_I;
  end

  msau_agu u_agu_x (
    .req_i     (XRD_REQ_I),
    .dsp_en_i  (DSP_EN && XRD_REQ_I.mode != MSAU_MODE_BITREV),
    .ea_o      (x_ea),
    .next_ea_o (x_next)
  );

  msau_agu u_agu_y (
    .req_i     (YRD_REQ_I),
    .dsp_en_i  (DSP_EN && YRD_REQ_I.mode != MSAU_MODE_BITREV),
    .ea_o      (y_ea),
    .next_ea_o (y_next)
  );

  msau_agu u_agu_w (
    .req_i     (wr_req_x),
    .dsp_en_i  (DSP_EN),
    .ea_o      (w_ea),
    .next_ea_o (w_next)
  );

  // Program counter
  always_comb begin
    st_nxt   = st_r;
    pc_nxt   = pc_r;
    case (st_r)
      MSAU_ST_RESET: begin
        pc_nxt = RESET_VECTOR;
        st_nxt = MSAU_ST_RUN;
      end
      MSAU_ST_RUN: begin
        if (trap_r) begin
          st_nxt = MSAU_ST_TRAP;
        end else if (FETCH_LOAD_I) begin
          pc_nxt = {FETCH_TARGET_I[23:1], 1'b0};
        end else if (FETCH_ADV_I) begin
          pc_nxt = pc_r + PROG_STEP;
        end else if (FETCH_BACK_I) begin
          pc_nxt = pc_r - PROG_STEP;
        end
      end
      MSAU_ST_TRAP: begin
        // Trap entry handled by the core; back to run next cycle, taking a vector load if present
        st_nxt = MSAU_ST_RUN;
        if (FETCH_LOAD_I) begin
          pc_nxt = {FETCH_TARGET_I[23:1], 1'b0};
        end
      end
      default: begin
        st_nxt = MSAU_ST_RESET;
      end
    endcase
    plo_nxt  = PROG_RDATA_I[15:0];
    pup_nxt  = {UPPER_PAD, PROG_RDATA_I[23:16]};
    pvec_nxt = pc_nxt <= VECTOR_LAST;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st_r   <= MSAU_ST_RESET;
      pc_r   <= RESET_VECTOR;
      plo_r  <= ZERO_WORD;
      pup_r  <= ZERO_WORD;
      pvec_r <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      pc_r   <= pc_nxt;
      plo_r  <= plo_nxt;
      pup_r  <= pup_nxt;
      pvec_r <= pvec_nxt;
    end
  end

  // Pages
  always_comb begin
    rpage_nxt = PAGE_WE_I ? READ_PAGE_I : rpage_r;
    wpage_nxt = PAGE_WE_I ? WRITE_PAGE_I : wpage_r;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rpage_r <= PAGE_RST;
      wpage_r <= PAGE_RST;
    end else begin
      rpage_r <= rpage_nxt;
      wpage_r <= wpage_nxt;
    end
  end

  // Data access: addresses issued, data returned one cycle later
  always_comb begin
    logic y_ok;
    y_ok = DSP_EN && MAC_CLASS_I && YRD_REQ_I.valid;
    xa_nxt = {rpage_r[7:0], x_ea};
    ya_nxt = {rpage_r[7:0], y_ea};
    wa_nxt = {wpage_r[7:0], w_ea};
    // Byte enables gated by the alignment check
    be_nxt = 2'b00;
    if (WR_REQ_I.valid && !misaligned(WR_REQ_I)) begin
      be_nxt = WR_REQ_I.is_byte ? (w_ea[0] ? 2'b10 : 2'b01)
                                : 2'b11;
    end
    wd_nxt = (WR_REQ_I.is_byte && w_ea[0])
           ? {WR_DATA_I[7:0], WR_DATA_I[7:0]} : WR_DATA_I;
    xrd_pend_nxt = XRD_REQ_I.valid;
    yrd_pend_nxt = y_ok;
    xbyte_nxt = XRD_REQ_I.is_byte;
    xa0_nxt   = x_ea[0];
    ybyte_nxt = YRD_REQ_I.is_byte;
    ya0_nxt   = y_ea[0];
    ximp_nxt  = implemented(x_ea, SFR_HIT_I);
    yimp_nxt  = y_ea >= Y_BASE && y_ea <= IMPL_LAST;
    xn_nxt = XRD_REQ_I.valid ? x_next : xn_r;
    yn_nxt = y_ok ? y_next : yn_r;
    wn_nxt = WR_REQ_I.valid ? w_next : wn_r;
    trap_nxt = misaligned(XRD_REQ_I) || misaligned(WR_REQ_I)
            || (y_ok && misaligned(YRD_REQ_I));
    xd_nxt = xd_r;
    yd_nxt = yd_r;
    wreg_nxt = wreg_r;
    if (xrd_pend_r) begin
      xd_nxt = ximp_r ? lane_sel(XMEM_RDATA_I, xbyte_r, xa0_r)
                      : ZERO_WORD;
      wreg_nxt = xbyte_r ? {WREG_OLD_I[15:8], xd_nxt[7:0]}
                         : xd_nxt;
    end
    if (yrd_pend_r) begin
      yd_nxt = yimp_r ? lane_sel(YMEM_RDATA_I, ybyte_r, ya0_r)
                      : ZERO_WORD;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      xa_r <= '0;
      ya_r <= '0;
      wa_r <= '0;
      be_r <= 2'b00;
      wd_r <= ZERO_WORD;
      xd_r <= ZERO_WORD;
      yd_r <= ZERO_WORD;
      wreg_r <= ZERO_WORD;
      xn_r <= ZERO_WORD;
      yn_r <= ZERO_WORD;
      wn_r <= ZERO_WORD;
      trap_r <= 1'b0;
      xrd_pend_r <= 1'b0;
      yrd_pend_r <= 1'b0;
      xbyte_r <= 1'b0;
      xa0_r <= 1'b0;
      ybyte_r <= 1'b0;
      ya0_r <= 1'b0;
      ximp_r <= 1'b0;
      yimp_r <= 1'b0;
    end else begin
      xa_r <= xa_nxt;
      ya_r <= ya_nxt;
      wa_r <= wa_nxt;
      be_r <= be_nxt;
      wd_r <= wd_nxt;
      xd_r <= xd_nxt;
      yd_r <= yd_nxt;
      wreg_r <= wreg_nxt;
      xn_r <= xn_nxt;
      yn_r <= yn_nxt;
      wn_r <= wn_nxt;
      trap_r <= trap_nxt;
      xrd_pend_r <= xrd_pend_nxt;
      yrd_pend_r <= yrd_pend_nxt;
      xbyte_r <= xbyte_nxt;
      xa0_r <= xa0_nxt;
      ybyte_r <= ybyte_nxt;
      ya0_r <= ya0_nxt;
      ximp_r <= ximp_nxt;
      yimp_r <= yimp_nxt;
    end
  end

  assign PROG_ADDR_O   = pc_r;
  assign PROG_LOWER_O  = plo_r;
  assign PROG_UPPER_O  = pup_r;
  assign PROG_VECTOR_O = pvec_r;
  assign XMEM_ADDR_O   = xa_r;
  assign YMEM_ADDR_O   = ya_r;
  assign WMEM_ADDR_O   = wa_r;
  assign WMEM_BE_O     = be_r;
  assign WMEM_DATA_O   = wd_r;
  assign XRD_DATA_O    = xd_r;
  assign YRD_DATA_O    = yd_r;
  assign WREG_DATA_O   = wreg_r;
  assign XRD_NEXT_EA_O = xn_r;
  assign YRD_NEXT_EA_O = yn_r;
  assign WR_NEXT_EA_O  = wn_r;
  assign ADDR_TRAP_O   = trap_r;

  pc_even_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    pc_r[0] == 1'b0) else $error("Program counter odd");

  pc_step_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (st_r == MSAU_ST_RUN && !trap_r && !FETCH_LOAD_I && FETCH_ADV_I)
    |=> pc_r == $past(pc_r) + PROG_STEP)
    else $error("Program counter step wrong");

  reset_start_a: assert property (@(posedge CLK_I)
    $fell(SYS_RST_I) |-> pc_r == RESET_VECTOR)
    else $error("Fetch not at reset vector");

  upper_pad_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    pup_r[15:8] == UPPER_PAD) else $error("Upper byte not zero");

  trap_word_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (XRD_REQ_I.valid && !XRD_REQ_I.is_byte && x_ea[0]) |=> trap_r)
    else $error("Odd word read no trap");

  write_suppress_a: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I)
    (WR_REQ_I.valid && !WR_REQ_I.is_byte && w_ea[0])
    |=> be_r == 2'b00 && trap_r)
    else $error("Misaligned write not suppressed");

  byte_lane_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (WR_REQ_I.valid && WR_REQ_I.is_byte) |=> $onehot(be_r))
    else $error("Byte write enables wrong");

  zero_read_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (xrd_pend_r && !ximp_r) |=> xd_r == ZERO_WORD)
    else $error("Unimplemented read not zero");

  byte_high_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (xrd_pend_r && xbyte_r) |=> xd_r[15:8] == 8'h00
    && wreg_r[15:8] == $past(WREG_OLD_I[15:8]))
    else $error("Byte load disturbed high byte");

  y_gate_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !MAC_CLASS_I |=> !yrd_pend_r)
    else $error("Y path used outside MAC class");

endmodule : msau_top

/* testbench/msau_mem_model.sv */
// Partner model: program array and X/Y data arrays facing the access unit
`timescale 1ns/100ps
module msau_mem_model
  import msau_pkg::*;
#(
  parameter logic [23:0] JUMP_WORD  = 24'h04_0A5C,
  parameter logic [23:0] START_ADDR = 24'h00_1A40
) (
  // Program side
  input  wire logic [23:0]           prog_addr_i,
  output logic [23:0]                prog_rdata_o,
  // Data side
  input  wire logic [EXT_ADDR_W-1:0] xmem_addr_i,
  input  wire logic [EXT_ADDR_W-1:0] ymem_addr_i,
  output logic [15:0]                xmem_rdata_o,
  output logic [15:0]                ymem_rdata_o
);
  function automatic logic [15:0] pat(input logic [23:0] a,
                                      input logic [15:0] k);
    return {a[15:1], 1'b0} ^ {a[23:16], 8'h5A} ^ k;
  endfunction : pat

  // Never zero-filled; the X pattern is never zero, so a zero X read can only come from the unit
  always_comb begin
    xmem_rdata_o = pat(xmem_addr_i, 16'hC3A5);
    ymem_rdata_o = pat(ymem_addr_i, 16'h3C5A);
    if (prog_addr_i == RESET_VECTOR) begin
      prog_rdata_o = JUMP_WORD;
    end else if (prog_addr_i == RESET_VECTOR + PROG_STEP) begin
      prog_rdata_o = START_ADDR;
    end else begin
      prog_rdata_o = {prog_addr_i[7:0] ^ 8'h96, prog_addr_i[15:0] ^ 16'h5AA5};
    end
  end
endmodule : msau_mem_model

/* testbench/test_msau_top.sv */
// Testbench: fetch, read, write and dual-path traffic for the access unit
`timescale 1ns/100ps
module test_msau_top;
  import msau_pkg::*;
  localparam logic [23:0] JUMP_WORD  = 24'h04_0A5C;
  localparam logic [23:0] START_ADDR = 24'h00_1A40;
  localparam int          CYC_LIMIT  = 6000;
  // Corner loads around the vector limit, odd target included
  localparam logic [23:0] VEC_T [4] = '{24'h00_0200, 24'h00_0202,
                                        24'h00_01FE, 24'h12_3457};
  // Corner data places: {ea, is_byte}
  localparam logic [16:0] RD_T [7] = '{{16'hCFFE, 1'b0}, {16'hD000, 1'b0},
    {16'h0FFE, 1'b0}, {16'hFFFF, 1'b1}, {16'h1001, 1'b0},
    {16'h2001, 1'b1}, {16'h0003, 1'b0}};
  logic CLK_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic FETCH_ADV_I = 1'b0, FETCH_BACK_I = 1'b0, FETCH_LOAD_I = 1'b0;
  logic [23:0] FETCH_TARGET_I = '0, PROG_RDATA_I, PROG_ADDR_O;
  logic [15:0] PROG_LOWER_O, PROG_UPPER_O;
  logic PROG_VECTOR_O, PAGE_WE_I = 1'b0, MAC_CLASS_I = 1'b0, SFR_HIT_I = 1'b0;
  logic [PAGE_W-1:0] READ_PAGE_I = PAGE_RST, WRITE_PAGE_I = PAGE_RST;
  msau_req_type XRD_REQ_I = '0, YRD_REQ_I = '0, WR_REQ_I = '0, rq;
  logic [15:0] WR_DATA_I = '0, WREG_OLD_I = '0, XMEM_RDATA_I, YMEM_RDATA_I;
  logic [23:0] XMEM_ADDR_O, YMEM_ADDR_O, WMEM_ADDR_O;
  logic [1:0]  WMEM_BE_O;
  logic [15:0] WMEM_DATA_O, XRD_DATA_O, YRD_DATA_O, WREG_DATA_O;
  logic [15:0] XRD_NEXT_EA_O, YRD_NEXT_EA_O, WR_NEXT_EA_O;
  logic        ADDR_TRAP_O;
  int          err_count = 0, n_tests = 0, cyc = 0, i;
  logic [8:0]  rpage = PAGE_RST, wpage = PAGE_RST;
  logic [23:0] exp_pc = RESET_VECTOR, tgt;
  logic [15:0] ylast = ZERO_WORD, ea, d;

  msau_top dut_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .FETCH_ADV_I(FETCH_ADV_I), .FETCH_BACK_I(FETCH_BACK_I),
    .FETCH_LOAD_I(FETCH_LOAD_I), .FETCH_TARGET_I(FETCH_TARGET_I),
    .PROG_RDATA_I(PROG_RDATA_I), .PROG_ADDR_O(PROG_ADDR_O),
    .PROG_LOWER_O(PROG_LOWER_O), .PROG_UPPER_O(PROG_UPPER_O),
    .PROG_VECTOR_O(PROG_VECTOR_O), .PAGE_WE_I(PAGE_WE_I),
    .READ_PAGE_I(READ_PAGE_I), .WRITE_PAGE_I(WRITE_PAGE_I),
    .XRD_REQ_I(XRD_REQ_I), .MAC_CLASS_I(MAC_CLASS_I),
    .YRD_REQ_I(YRD_REQ_I), .WR_REQ_I(WR_REQ_I), .WR_DATA_I(WR_DATA_I),
    .WREG_OLD_I(WREG_OLD_I), .XMEM_RDATA_I(XMEM_RDATA_I),
    .YMEM_RDATA_I(YMEM_RDATA_I), .SFR_HIT_I(SFR_HIT_I),
    .XMEM_ADDR_O(XMEM_ADDR_O), .YMEM_ADDR_O(YMEM_ADDR_O),
    .WMEM_ADDR_O(WMEM_ADDR_O), .WMEM_BE_O(WMEM_BE_O),
    .WMEM_DATA_O(WMEM_DATA_O), .XRD_DATA_O(XRD_DATA_O),
    .YRD_DATA_O(YRD_DATA_O), .WREG_DATA_O(WREG_DATA_O),
    .XRD_NEXT_EA_O(XRD_NEXT_EA_O), .YRD_NEXT_EA_O(YRD_NEXT_EA_O),
    .WR_NEXT_EA_O(WR_NEXT_EA_O), .ADDR_TRAP_O(ADDR_TRAP_O));

  msau_mem_model #(.JUMP_WORD(JUMP_WORD), .START_ADDR(START_ADDR)) mem_u (
    .prog_addr_i(PROG_ADDR_O), .prog_rdata_o(PROG_RDATA_I),
    .xmem_addr_i(XMEM_ADDR_O), .ymem_addr_i(YMEM_ADDR_O),
    .xmem_rdata_o(XMEM_RDATA_I), .ymem_rdata_o(YMEM_RDATA_I));

  always #10 CLK_I = ~CLK_I;

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Hang guard sized well above the scripted traffic
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == CYC_LIMIT) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [23:0] seen,
                     input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] mem_word(input logic [23:0] a,
                                           input logic [15:0] k);
    return {a[15:1], 1'b0} ^ {a[23:16], 8'h5A} ^ k;
  endfunction : mem_word

  function automatic logic [23:0] prog_word(input logic [23:0] a);
    if (a == RESET_VECTOR) return JUMP_WORD;
    if (a == RESET_VECTOR + PROG_STEP) return START_ADDR;
    return {a[7:0] ^ 8'h96, a[15:0] ^ 16'h5AA5};
  endfunction : prog_word

  function automatic msau_req_type req(input logic [15:0] a, input logic b);
    req = '0;
    req.valid = 1'b1;
    req.is_byte = b;
    req.ea = a;
    req.mod_end = 16'hFFFF;
  endfunction : req

  task automatic pc_cmd(input logic adv, input logic bk, input logic ld,
                        input logic [23:0] t);
    logic [23:0] pw;
    FETCH_ADV_I <= adv;
    FETCH_BACK_I <= bk;
    FETCH_LOAD_I <= ld;
    FETCH_TARGET_I <= t;
    if (ld) exp_pc = {t[23:1], 1'b0};
    else if (adv) exp_pc = exp_pc + PROG_STEP;
    else if (bk) exp_pc = exp_pc - PROG_STEP;
    @(negedge CLK_I);
    {FETCH_ADV_I, FETCH_BACK_I, FETCH_LOAD_I} <= 3'b000;
    repeat (2) @(negedge CLK_I);
    pw = prog_word(exp_pc);
    chk("pc", PROG_ADDR_O, exp_pc);
    chk("prog lower", PROG_LOWER_O, pw[15:0]);
    chk("prog upper", PROG_UPPER_O, {UPPER_PAD, pw[23:16]});
    chk("vector", PROG_VECTOR_O, exp_pc <= VECTOR_LAST);
  endtask : pc_cmd

  task automatic set_page(input logic [8:0] r, input logic [8:0] w);
    PAGE_WE_I <= 1'b1;
    READ_PAGE_I <= r;
    WRITE_PAGE_I <= w;
    @(negedge CLK_I);
    PAGE_WE_I <= 1'b0;
    rpage = r;
    wpage = w;
    @(negedge CLK_I);
  endtask : set_page

  task automatic xread(input logic [15:0] a, input logic b, input logic h);
    logic [15:0] w, e, old, nx;
    logic        bad;
    bad = !b && a[0];
    old = $urandom;
    w = mem_word({rpage[7:0], a}, 16'hC3A5);
    if (a > IMPL_LAST || (a <= SFR_LAST && !h)) w = ZERO_WORD;
    e = !b ? w : (a[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
    XRD_REQ_I <= req(a, b);
    SFR_HIT_I <= h;
    WREG_OLD_I <= old;
    @(negedge CLK_I);
    XRD_REQ_I <= '0;
    // Address and trap stand for one cycle only
    nx = a + (b ? BYTE_STEP : WORD_STEP);
    chk("x addr", XMEM_ADDR_O, {rpage[7:0], a});
    chk("x next", XRD_NEXT_EA_O, nx);
    chk("x trap", ADDR_TRAP_O, bad);
    @(negedge CLK_I);
    if (!bad) chk("x data", XRD_DATA_O, e);
    if (b) chk("wreg", WREG_DATA_O, {old[15:8], e[7:0]});
  endtask : xread

  task automatic xwrite(input logic [15:0] a, input logic b,
                        input logic [15:0] v);
    logic        bad;
    logic [1:0]  be;
    logic [15:0] nx, sw, ew;
    bad = !b && a[0];
    WR_REQ_I <= req(a, b);
    WR_DATA_I <= v;
    @(negedge CLK_I);
    WR_REQ_I <= '0;
    nx = a + (b ? BYTE_STEP : WORD_STEP);
    be = bad ? 2'b00 : (!b ? 2'b11 : {a[0], !a[0]});
    sw = !b ? WMEM_DATA_O
            : {8'h00, a[0] ? WMEM_DATA_O[15:8] : WMEM_DATA_O[7:0]};
    ew = !b ? v : {8'h00, v[7:0]};
    chk("w be", WMEM_BE_O, be);
    chk("w trap", ADDR_TRAP_O, bad);
    chk("w next", WR_NEXT_EA_O, nx);
    if (!bad) chk("w addr", WMEM_ADDR_O, {wpage[7:0], a});
    if (!bad) chk("w data", sw, ew);
    @(negedge CLK_I);
  endtask : xwrite

  task automatic dual(input logic [15:0] xa, input logic [15:0] ya,
                      input logic mac);
    XRD_REQ_I <= req(xa, 1'b0);
    YRD_REQ_I <= req(ya, 1'b0);
    MAC_CLASS_I <= mac;
    @(negedge CLK_I);
    XRD_REQ_I <= '0;
    YRD_REQ_I <= '0;
    MAC_CLASS_I <= 1'b0;
    if (mac) chk("y addr", YMEM_ADDR_O[15:0], ya);
    if (mac) chk("y next", YRD_NEXT_EA_O, ya + WORD_STEP);
    if (mac) ylast = mem_word({rpage[7:0], ya}, 16'h3C5A);
    @(negedge CLK_I);
    chk("dual x", XRD_DATA_O, mem_word({rpage[7:0], xa}, 16'hC3A5));
    chk("dual y", YRD_DATA_O, ylast);
  endtask : dual

  initial begin
    void'($urandom(52040));
    repeat (10) @(negedge CLK_I);
    SYS_RST_I <= 1'b0;
    chk("pc reset", PROG_ADDR_O, RESET_VECTOR);
    chk("vec reset", PROG_VECTOR_O, 1'b1);
    pc_cmd(1'b0, 1'b0, 1'b0, '0);
    pc_cmd(1'b1, 1'b0, 1'b0, '0);
    tgt = {PROG_UPPER_O[7:0], PROG_LOWER_O};
    chk("start", tgt, START_ADDR);
    pc_cmd(1'b0, 1'b0, 1'b1, tgt);
    foreach (VEC_T[k]) pc_cmd(1'b0, 1'b0, 1'b1, VEC_T[k]);
    for (i = 0; i < 30; i++) pc_cmd($urandom, $urandom, $urandom, $urandom);
    xread(16'h1000, 1'b0, 1'b0);
    foreach (RD_T[k]) xread(RD_T[k][16:1], RD_T[k][0], 1'b0);
    xread(16'h0FFE, 1'b0, 1'b1);
    foreach (RD_T[k]) xwrite(RD_T[k][16:1], RD_T[k][0], 16'hA55A);
    dual(16'h2000, 16'h9000, 1'b1);
    dual(16'h2002, 16'h9002, 1'b0);
    // Near-direct read folds to 13 bits; modulo and bit-reverse writes
    rq = req(16'hE002, 1'b0);
    rq.near_direct = 1'b1;
    XRD_REQ_I <= rq;
    rq = req(16'h2010, 1'b0);
    rq.mode = MSAU_MODE_MODULO;
    rq.mod_start = 16'h2000;
    rq.mod_end = 16'h2010;
    WR_REQ_I <= rq;
    @(negedge CLK_I);
    chk("near addr", XMEM_ADDR_O, {rpage[7:0], 16'h0002});
    chk("mod next", WR_NEXT_EA_O, 16'h2000);
    rq = req(16'h0002, 1'b0);
    rq.mode = MSAU_MODE_BITREV;
    XRD_REQ_I <= '0;
    WR_REQ_I <= rq;
    @(negedge CLK_I);
    WR_REQ_I <= '0;
    // Reverse carry: bit one overflows into bit zero
    chk("brev next", WR_NEXT_EA_O, 16'h0001);
    @(negedge CLK_I);
    for (i = 0; i < 150; i++) begin
      if (i % 25 == 0) set_page($urandom, $urandom);
      ea = $urandom;
      d = $urandom;
      xread(ea, d[0], d[1]);
      xwrite(d ^ ea, ea[3], $urandom);
      dual({3'b001, ea[12:1], 1'b0}, {4'h9, ea[11:1], 1'b0}, d[2]);
    end
    end_sim();
  end

endmodule : test_msau_top
